// *** include/dlcr_pkg.sv ***
package dlcr_pkg;

  // Register offsets
  localparam logic [7:0] INPUT_FORMAT_CONTROL_ADDR     = 8'h1F;
  localparam logic [7:0] COLOUR_SPACE_CONTROL_ADDR     = 8'h31;
  localparam logic [7:0] PATTERN_AND_SOFT_RESET_ADDR   = 8'h48;
  localparam logic [7:0] VERSION_CODE_ADDR             = 8'h4A;
  localparam logic [7:0] DEVICE_CODE_ADDR              = 8'h4B;
  localparam logic [7:0] LINK_POWER_DOWN_ADDR          = 8'h63;
  localparam logic [7:0] LINK_ENCODING_CONTROL_ADDR    = 8'h64;
  localparam logic [7:0] PANEL_PROTECTION_CONTROL_ADDR = 8'h66;
  localparam logic [7:0] POWER_ON_DELAY_LOW_ADDR       = 8'h67;
  localparam logic [7:0] BACKLIGHT_ON_DELAY_ADDR       = 8'h68;
  localparam logic [7:0] BACKLIGHT_OFF_DELAY_ADDR      = 8'h69;
  localparam logic [7:0] LINK_OFF_DELAY_LOW_ADDR       = 8'h6A;

  // Reset values
  localparam logic [7:0] INPUT_FORMAT_CONTROL_RST     = 8'h80;
  localparam logic [7:0] COLOUR_SPACE_CONTROL_RST     = 8'h00;
  localparam logic [7:0] PATTERN_AND_SOFT_RESET_RST   = 8'h18;
  localparam logic [7:0] LINK_POWER_DOWN_RST          = 8'h00;
  localparam logic [7:0] LINK_ENCODING_CONTROL_RST    = 8'h0D;
  localparam logic [7:0] PANEL_PROTECTION_CONTROL_RST = 8'h01;
  localparam logic [7:0] DELAY_REG_RST                = 8'h00;

  // Identity values, arbitrary
  localparam logic [7:0] VERSION_CODE_VALUE     = 8'h5C;
  localparam logic [7:0] DEVICE_CODE_BASE       = 8'h44;

  // Field positions
  localparam int INPUT_BUFFER_SELECT_BIT     = 7;
  localparam int COLOUR_CONVERT_BIT          = 0;
  localparam int DATAPATH_RESET_N_BIT        = 3;
  localparam int REGISTER_RESET_N_BIT        = 4;
  localparam int LINK_PATH_OFF_BIT           = 6;
  localparam int BIT_MAPPING_SELECT_BIT      = 0;
  localparam int ODD_EVEN_SWAP_BIT           = 1;
  localparam int DITHER_BYPASS_BIT           = 3;
  localparam int WIDE_OUTPUT_SELECT_BIT      = 5;
  localparam int PANEL_POWER_REQUEST_BIT     = 0;
  localparam int SYNC_DETECT_BYPASS_BIT      = 1;
  localparam int PLL_LOCKED_BIT              = 2;
  localparam int LOCK_FORCE_VALUE_BIT        = 3;
  localparam int LOCK_SOURCE_SELECT_BIT      = 4;
  localparam int BACKLIGHT_ON_REQUEST_BIT    = 5;
  localparam int SYNC_STABLE_BIT             = 6;
  localparam int DELAY_MSB_BIT               = 7;
  localparam int DEVICE_CODE_STRAP_HI_BIT    = 5;
  localparam int DEVICE_CODE_STRAP_LO_BIT    = 0;
  localparam logic [7:0] PANEL_PROTECTION_WRITE_MASK = 8'h3B;
  localparam logic [2:0] YCRCB_FORMAT       = 3'h4;

  // Timing
  localparam int CLOCK_PERIOD_NS   = 4;
  localparam int MILLISECOND_NS    = 1000000;
  localparam int TICK_CYCLES       = MILLISECOND_NS / CLOCK_PERIOD_NS;
  localparam int MIN_DELAY_MS      = 2;
  localparam int SYNC_HOLD_MS      = 2;
  localparam int FRAME_HOLD_MS     = 100;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } dlcr_pixel_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       write;
    logic       read;
    logic [7:0] wdata;
  } dlcr_reg_req_t;

  typedef enum logic [2:0] {
    SEQ_OFF, SEQ_WAIT_READY, SEQ_POWER_ON, SEQ_LINK_ON,
    SEQ_BACKLIGHT, SEQ_BACKLIGHT_OFF, SEQ_LINK_OFF
  } dlcr_seq_t;

endpackage

// *** design/dlcr_top.sv ***
`timescale 1ns/100ps
module dlcr_top
  import dlcr_pkg::*;
#(
  parameter int CYCLES_PER_MS = TICK_CYCLES,
  parameter int BAR_WIDTH     = 160
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // Register port
  input  wire dlcr_reg_req_t reg_req,
  output logic [7:0]       reg_rdata,
  output logic             reg_rvalid,
  // Pins from outside
  input  wire logic        config_strap,
  input  wire logic        pll_lock_pin,
  input  wire logic        hsync_pin,
  input  wire logic        vsync_pin,
  // Pixel input
  input  wire dlcr_pixel_t pixel_in,
  input  wire logic        pixel_in_valid,
  // Input port configuration
  output logic [2:0]       input_format_select,
  output logic             input_buffer_select,
  // Link side
  output dlcr_pixel_t      link_pixel,
  output logic             link_pixel_valid,
  output logic             link_enable,
  output logic             link_path_off,
  output logic             bit_mapping_standard_select,
  output logic             odd_even_swap,
  output logic             wide_output_select,
  // Panel
  output logic             panel_power_enable,
  output logic             backlight_enable
);

  logic [7:0] input_format_control;
  logic [7:0] colour_space_control;
  logic [7:0] pattern_and_soft_reset;
  logic [7:0] link_power_down;
  logic [7:0] link_encoding_control;
  logic [7:0] panel_protection_control;
  logic [7:0] power_on_delay_low;
  logic [7:0] backlight_on_delay;
  logic [7:0] backlight_off_delay;
  logic [7:0] link_off_delay_low;
  logic [7:0] device_code;
  logic       reg_reset;
  logic       dp_reset;

  logic [1:0] strap_sync;
  logic [1:0] lock_sync;
  logic [1:0] hs_sync;
  logic [1:0] vs_sync;
  logic       hs_last;
  logic       vs_last;
  logic       pll_locked;
  logic       sync_stable;

  logic [31:0] tick_count;
  logic        ms_tick;
  logic [7:0]  hs_age;
  logic [7:0]  vs_age;

  dlcr_seq_t   seq_state;
  logic [9:0]  seq_ms;
  logic        lock_ok;
  logic        link_ready;
  logic [9:0]  t1_ms;
  logic [9:0]  t2_ms;
  logic [9:0]  t3_ms;
  logic [9:0]  t4_ms;

  logic [10:0] pixel_x;
  dlcr_pixel_t stage1;
  logic        stage1_valid;
  logic [15:0] lfsr;

  // Nine-bit field plus one, floored at the minimum
  function automatic logic [9:0] delay_1ms(input logic [8:0] field);
    logic [9:0] ms;
    ms = {1'b0, field} + 10'h001;
    if (ms < 10'(MIN_DELAY_MS))
      ms = 10'(MIN_DELAY_MS);
    return ms;
  endfunction

  // Seven-bit field in 2 ms steps, from 2 ms
  function automatic logic [9:0] delay_2ms(input logic [6:0] field);
    return {2'b00, field, 1'b0} + 10'h002;
  endfunction

  function automatic logic [7:0] clamp8(input logic signed [17:0] v);
    if (v < 0)
      return 8'h00;
    else if (v > 18'sd255)
      return 8'hFF;
    else
      return v[7:0];
  endfunction

  function automatic logic [7:0] dither8(input logic [7:0] c, input logic [1:0] n);
    logic [8:0] s;
    s = {1'b0, c} + {7'h00, n};
    if (s[8])
      s = 9'h0FF;
    return {s[7:2], 2'b00};
  endfunction

  assign reg_reset = reset | ~pattern_and_soft_reset[REGISTER_RESET_N_BIT];
  assign dp_reset  = reset | ~pattern_and_soft_reset[DATAPATH_RESET_N_BIT];

  // Pin synchronisers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      strap_sync <= 2'b00;
      lock_sync  <= 2'b00;
      hs_sync    <= 2'b00;
      vs_sync    <= 2'b00;
      hs_last    <= 1'b0;
      vs_last    <= 1'b0;
    end else begin
      strap_sync <= {strap_sync[0], config_strap};
      lock_sync  <= {lock_sync[0], pll_lock_pin};
      hs_sync    <= {hs_sync[0], hsync_pin};
      vs_sync    <= {vs_sync[0], vsync_pin};
      hs_last    <= hs_sync[1];
      vs_last    <= vs_sync[1];
    end
  end

  // Strap caught after reset; code then follows the synchronised pin
  always_ff @(posedge core_clk) begin
    if (reset) begin
      device_code <= DEVICE_CODE_BASE;
    end else begin
      device_code <= DEVICE_CODE_BASE;
      device_code[DEVICE_CODE_STRAP_HI_BIT] <= strap_sync[1];
      device_code[DEVICE_CODE_STRAP_LO_BIT] <= strap_sync[1];
    end
  end

  // Millisecond tick
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tick_count <= 32'h0000_0000;
      ms_tick    <= 1'b0;
    end else if (tick_count >= 32'(CYCLES_PER_MS - 1)) begin
      tick_count <= 32'h0000_0000;
      ms_tick    <= 1'b1;
    end else begin
      tick_count <= tick_count + 32'h0000_0001;
      ms_tick    <= 1'b0;
    end
  end

  // Sync stability: edges seen recently enough on both syncs
  always_ff @(posedge core_clk) begin
    if (reset) begin
      hs_age      <= 8'hFF;
      vs_age      <= 8'hFF;
      sync_stable <= 1'b0;
      pll_locked  <= 1'b0;
    end else begin
      if (hs_sync[1] & ~hs_last)
        hs_age <= 8'h00;
      else if (ms_tick && hs_age != 8'hFF)
        hs_age <= hs_age + 8'h01;
      if (vs_sync[1] & ~vs_last)
        vs_age <= 8'h00;
      else if (ms_tick && vs_age != 8'hFF)
        vs_age <= vs_age + 8'h01;
      sync_stable <= (hs_age < 8'(SYNC_HOLD_MS)) && (vs_age < 8'(FRAME_HOLD_MS));
      pll_locked  <= lock_sync[1];
    end
  end

  // Register writes
  always_ff @(posedge core_clk) begin
    if (reg_reset) begin
      input_format_control     <= INPUT_FORMAT_CONTROL_RST;
      colour_space_control     <= COLOUR_SPACE_CONTROL_RST;
      pattern_and_soft_reset   <= PATTERN_AND_SOFT_RESET_RST;
      link_power_down          <= LINK_POWER_DOWN_RST;
      link_encoding_control    <= LINK_ENCODING_CONTROL_RST;
      panel_protection_control <= PANEL_PROTECTION_CONTROL_RST;
      power_on_delay_low       <= DELAY_REG_RST;
      backlight_on_delay       <= DELAY_REG_RST;
      backlight_off_delay      <= DELAY_REG_RST;
      link_off_delay_low       <= DELAY_REG_RST;
    end else if (reg_req.write) begin
      if (reg_req.addr == INPUT_FORMAT_CONTROL_ADDR) begin
        input_format_control <= reg_req.wdata;
      end else if (reg_req.addr == COLOUR_SPACE_CONTROL_ADDR) begin
        colour_space_control <= reg_req.wdata;
      end else if (reg_req.addr == PATTERN_AND_SOFT_RESET_ADDR) begin
        pattern_and_soft_reset <= reg_req.wdata;
      end else if (reg_req.addr == LINK_POWER_DOWN_ADDR) begin
        link_power_down <= reg_req.wdata;
      end else if (reg_req.addr == LINK_ENCODING_CONTROL_ADDR) begin
        link_encoding_control <= reg_req.wdata;
      end else if (reg_req.addr == PANEL_PROTECTION_CONTROL_ADDR) begin
        panel_protection_control <= reg_req.wdata & PANEL_PROTECTION_WRITE_MASK;
      end else if (reg_req.addr == POWER_ON_DELAY_LOW_ADDR) begin
        power_on_delay_low <= reg_req.wdata;
      end else if (reg_req.addr == BACKLIGHT_ON_DELAY_ADDR) begin
        backlight_on_delay <= reg_req.wdata;
      end else if (reg_req.addr == BACKLIGHT_OFF_DELAY_ADDR) begin
        backlight_off_delay <= reg_req.wdata;
      end else if (reg_req.addr == LINK_OFF_DELAY_LOW_ADDR) begin
        link_off_delay_low <= reg_req.wdata;
      end
    end
  end

  // Register reads, one cycle later; unmapped reads return zero
  always_ff @(posedge core_clk) begin
    if (reset) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_req.read;
      if (!reg_req.read) begin
        reg_rdata <= 8'h00;
      end else if (reg_req.addr == INPUT_FORMAT_CONTROL_ADDR) begin
        reg_rdata <= input_format_control;
      end else if (reg_req.addr == COLOUR_SPACE_CONTROL_ADDR) begin
        reg_rdata <= colour_space_control;
      end else if (reg_req.addr == PATTERN_AND_SOFT_RESET_ADDR) begin
        reg_rdata <= pattern_and_soft_reset;
      end else if (reg_req.addr == VERSION_CODE_ADDR) begin
        reg_rdata <= VERSION_CODE_VALUE;
      end else if (reg_req.addr == DEVICE_CODE_ADDR) begin
        reg_rdata <= device_code;
      end else if (reg_req.addr == LINK_POWER_DOWN_ADDR) begin
        reg_rdata <= link_power_down;
      end else if (reg_req.addr == LINK_ENCODING_CONTROL_ADDR) begin
        reg_rdata <= link_encoding_control;
      end else if (reg_req.addr == PANEL_PROTECTION_CONTROL_ADDR) begin
        reg_rdata <= panel_protection_control;
        reg_rdata[PLL_LOCKED_BIT]  <= pll_locked;
        reg_rdata[SYNC_STABLE_BIT] <= sync_stable;
      end else if (reg_req.addr == POWER_ON_DELAY_LOW_ADDR) begin
        reg_rdata <= power_on_delay_low;
      end else if (reg_req.addr == BACKLIGHT_ON_DELAY_ADDR) begin
        reg_rdata <= backlight_on_delay;
      end else if (reg_req.addr == BACKLIGHT_OFF_DELAY_ADDR) begin
        reg_rdata <= backlight_off_delay;
      end else if (reg_req.addr == LINK_OFF_DELAY_LOW_ADDR) begin
        reg_rdata <= link_off_delay_low;
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // Configuration levels to input port and serializer
  always_ff @(posedge core_clk) begin
    if (reset) begin
      input_format_select         <= INPUT_FORMAT_CONTROL_RST[2:0];
      input_buffer_select         <= INPUT_FORMAT_CONTROL_RST[INPUT_BUFFER_SELECT_BIT];
      bit_mapping_standard_select <= LINK_ENCODING_CONTROL_RST[BIT_MAPPING_SELECT_BIT];
      odd_even_swap               <= LINK_ENCODING_CONTROL_RST[ODD_EVEN_SWAP_BIT];
      wide_output_select          <= LINK_ENCODING_CONTROL_RST[WIDE_OUTPUT_SELECT_BIT];
      link_path_off               <= LINK_POWER_DOWN_RST[LINK_PATH_OFF_BIT];
    end else begin
      input_format_select         <= input_format_control[2:0];
      input_buffer_select         <= input_format_control[INPUT_BUFFER_SELECT_BIT];
      bit_mapping_standard_select <= link_encoding_control[BIT_MAPPING_SELECT_BIT];
      odd_even_swap               <= link_encoding_control[ODD_EVEN_SWAP_BIT];
      wide_output_select          <= link_encoding_control[WIDE_OUTPUT_SELECT_BIT];
      link_path_off               <= link_power_down[LINK_PATH_OFF_BIT];
    end
  end

  // Sequencer delays
  assign t1_ms = delay_1ms({backlight_on_delay[DELAY_MSB_BIT], power_on_delay_low});
  assign t2_ms = delay_2ms(backlight_on_delay[6:0]);
  assign t3_ms = delay_2ms(backlight_off_delay[6:0]);
  assign t4_ms = delay_1ms({backlight_off_delay[DELAY_MSB_BIT], link_off_delay_low});

  assign lock_ok = panel_protection_control[LOCK_SOURCE_SELECT_BIT] ?
                   panel_protection_control[LOCK_FORCE_VALUE_BIT] : pll_locked;
  assign link_ready = lock_ok &
                      (sync_stable | panel_protection_control[SYNC_DETECT_BYPASS_BIT]);

  // Power sequencer; power-off runs SEQ_BACKLIGHT_OFF then SEQ_LINK_OFF, or only SEQ_LINK_OFF when left before SEQ_LINK_ON
  always_ff @(posedge core_clk) begin
    if (reset) begin
      seq_state <= SEQ_OFF;
      seq_ms    <= 10'h000;
    end else begin
      if (ms_tick)
        seq_ms <= seq_ms + 10'h001;
      case (seq_state)
        SEQ_OFF: begin
          seq_ms <= 10'h000;
          if (panel_protection_control[PANEL_POWER_REQUEST_BIT] && !link_path_off)
            seq_state <= SEQ_WAIT_READY;
        end
        SEQ_WAIT_READY: begin
          seq_ms <= 10'h000;
          if (!panel_protection_control[PANEL_POWER_REQUEST_BIT] || link_path_off)
            seq_state <= SEQ_LINK_OFF;
          else if (link_ready)
            seq_state <= SEQ_POWER_ON;
        end
        SEQ_POWER_ON: begin
          if (!panel_protection_control[PANEL_POWER_REQUEST_BIT] || link_path_off) begin
            seq_state <= SEQ_LINK_OFF;
            seq_ms    <= 10'h000;
          end else if (seq_ms >= t1_ms) begin
            seq_state <= SEQ_LINK_ON;
            seq_ms    <= 10'h000;
          end
        end
        SEQ_LINK_ON: begin
          if (!panel_protection_control[PANEL_POWER_REQUEST_BIT] || link_path_off) begin
            seq_state <= SEQ_BACKLIGHT_OFF;
            seq_ms    <= 10'h000;
          end else if (seq_ms >= t2_ms) begin
            seq_state <= SEQ_BACKLIGHT;
            seq_ms    <= 10'h000;
          end
        end
        SEQ_BACKLIGHT: begin
          seq_ms <= 10'h000;
          if (!panel_protection_control[PANEL_POWER_REQUEST_BIT] || link_path_off)
            seq_state <= SEQ_BACKLIGHT_OFF;
        end
        SEQ_BACKLIGHT_OFF: begin
          if (seq_ms >= t3_ms) begin
            seq_state <= SEQ_LINK_OFF;
            seq_ms    <= 10'h000;
          end
        end
        SEQ_LINK_OFF: begin
          if (seq_ms >= t4_ms) begin
            seq_state <= SEQ_OFF;
            seq_ms    <= 10'h000;
          end
        end
        default: begin
          seq_state <= SEQ_OFF;
        end
      endcase
    end
  end

  // Panel outputs
  always_ff @(posedge core_clk) begin
    if (reset) begin
      panel_power_enable <= 1'b0;
      link_enable        <= 1'b0;
      backlight_enable   <= 1'b0;
    end else begin
      panel_power_enable <= seq_state != SEQ_OFF;
      link_enable        <= !link_path_off && (seq_state == SEQ_LINK_ON || seq_state == SEQ_BACKLIGHT ||
                            seq_state == SEQ_BACKLIGHT_OFF);
      // Power-down drops the backlight t3_ms before the link; link_path_off drops link and backlight on the same edge
      backlight_enable   <= seq_state == SEQ_BACKLIGHT && !link_path_off &&
                            panel_protection_control[BACKLIGHT_ON_REQUEST_BIT];
    end
  end

  // Stage 1: colour conversion and pattern substitution
  always_ff @(posedge core_clk) begin
    if (dp_reset) begin
      pixel_x      <= 11'h000;
      stage1       <= '0;
      stage1_valid <= 1'b0;
    end else begin
      stage1_valid <= pixel_in_valid;
      if (hs_sync[1] & ~hs_last)
        pixel_x <= 11'h000;
      else if (pixel_in_valid)
        pixel_x <= pixel_x + 11'h001;
      if (pixel_in_valid) begin
        case (pattern_and_soft_reset[1:0])
          2'b00: begin
            // Cr on red, Y on green, Cb on blue
            if (colour_space_control[COLOUR_CONVERT_BIT] && input_format_control[2:0] == YCRCB_FORMAT) begin
              stage1.red   <= clamp8(18'(signed'({10'h000, pixel_in.green})) +
                              18'(((signed'({10'h000, pixel_in.red}) - 18'sd128) * 18'sd359) >>> 8));
              stage1.green <= clamp8(18'(signed'({10'h000, pixel_in.green})) -
                              18'((((signed'({10'h000, pixel_in.blue}) - 18'sd128) * 18'sd88) +
                              ((signed'({10'h000, pixel_in.red}) - 18'sd128) * 18'sd183)) >>> 8));
              stage1.blue  <= clamp8(18'(signed'({10'h000, pixel_in.green})) +
                              18'(((signed'({10'h000, pixel_in.blue}) - 18'sd128) * 18'sd454) >>> 8));
            end else begin
              stage1 <= pixel_in;
            end
          end
          2'b01: begin
            // Eight bars: white, yellow, cyan, green, magenta, red, blue, black
            stage1.red   <= (3'(pixel_x / 11'(BAR_WIDTH)) inside {3'd0, 3'd1, 3'd4, 3'd5}) ? 8'hFF : 8'h00;
            stage1.green <= (3'(pixel_x / 11'(BAR_WIDTH)) inside {3'd0, 3'd1, 3'd2, 3'd3}) ? 8'hFF : 8'h00;
            stage1.blue  <= (3'(pixel_x / 11'(BAR_WIDTH)) inside {3'd0, 3'd2, 3'd4, 3'd6}) ? 8'hFF : 8'h00;
          end
          2'b10: begin
            stage1 <= {pixel_x[7:0], pixel_x[7:0], pixel_x[7:0]};
          end
          default: begin
            stage1 <= '0;
          end
        endcase
      end
    end
  end

  // Stage 2: dither and width reduction toward the link
  always_ff @(posedge core_clk) begin
    if (dp_reset) begin
      lfsr             <= 16'hACE1;
      link_pixel       <= '0;
      link_pixel_valid <= 1'b0;
    end else begin
      lfsr             <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      link_pixel_valid <= stage1_valid && link_enable;
      if (!link_enable) begin
        link_pixel <= '0;
      end else if (wide_output_select || link_encoding_control[DITHER_BYPASS_BIT]) begin
        // Wide mode, or bypass: low bits only dropped in narrow mode
        link_pixel.red   <= wide_output_select ? stage1.red   : {stage1.red[7:2], 2'b00};
        link_pixel.green <= wide_output_select ? stage1.green : {stage1.green[7:2], 2'b00};
        link_pixel.blue  <= wide_output_select ? stage1.blue  : {stage1.blue[7:2], 2'b00};
      end else begin
        link_pixel.red   <= dither8(stage1.red, lfsr[1:0]);
        link_pixel.green <= dither8(stage1.green, lfsr[3:2]);
        link_pixel.blue  <= dither8(stage1.blue, lfsr[5:4]);
      end
    end
  end

endmodule // dlcr_top

// *** testbench/dlcr_top_properties.sv ***
`timescale 1ns/100ps
module dlcr_top_properties
  import dlcr_pkg::*;
(
  // Watched ports
  input wire logic          core_clk,
  input wire logic          reset,
  input wire dlcr_reg_req_t reg_req,
  input wire logic [7:0]    reg_rdata,
  input wire logic [2:0]    input_format_select,
  input wire logic          input_buffer_select,
  input wire logic          wide_output_select,
  input wire logic          link_path_off,
  input wire logic          link_enable,
  input wire logic          panel_power_enable,
  input wire logic          backlight_enable
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  chk_version_fixed: assert property (reg_req.read && reg_req.addr == VERSION_CODE_ADDR
    |=> reg_rdata == VERSION_CODE_VALUE) else $error("bad version");
  chk_device_strap: assert property (reg_req.read && reg_req.addr == DEVICE_CODE_ADDR
    |=> (reg_rdata & 8'hDE) == DEVICE_CODE_BASE && reg_rdata[5] == reg_rdata[0]) else $error("bad device");
  chk_format_copy: assert property (reg_req.write && reg_req.addr == INPUT_FORMAT_CONTROL_ADDR |=> ##1
    {input_buffer_select, input_format_select} == {$past(reg_req.wdata[7], 2), $past(reg_req.wdata[2:0], 2)})
    else $error("bad format");
  chk_width_copy: assert property (reg_req.write && reg_req.addr == LINK_ENCODING_CONTROL_ADDR |=> ##1
    wide_output_select == $past(reg_req.wdata[5], 2)) else $error("bad width");
  chk_link_powerdown: assert property (link_path_off |-> ##[0:3] !link_enable) else $error("link on");
  chk_backlight_gate: assert property (backlight_enable |-> link_enable && panel_power_enable) else $error("bl");
  chk_link_order: assert property ($fell(link_enable) |-> !backlight_enable) else $error("link order");
  chk_power_order: assert property ($fell(panel_power_enable) |-> !link_enable) else $error("power order");
  cover property ($rose(link_enable));
  cover property ($rose(backlight_enable));
  cover property ($fell(panel_power_enable));
endmodule // dlcr_top_properties
bind dlcr_top dlcr_top_properties dlcr_top_properties_inst (.*);

// *** testbench/dlcr_panel_model.sv ***
`timescale 1ns/100ps
module dlcr_panel_model (
  // Clock and sync source control
  input  wire logic core_clk,
  input  wire logic sync_run,
  // Panel enables
  input  wire logic panel_power_enable,
  input  wire logic link_enable,
  input  wire logic backlight_enable,
  // Sync towards the device, order fault towards the testbench
  output logic      hsync_pin,
  output logic      vsync_pin,
  output logic      order_fault
);
  logic [3:0] phase = 4'h0;
  always_ff @(posedge core_clk) begin
    phase <= phase + 4'h1;
    hsync_pin <= sync_run & phase[1];
    vsync_pin <= sync_run & phase[3];
    // A lit backlight on a dark panel shows garbage
    order_fault <= backlight_enable & !(link_enable & panel_power_enable);
  end
endmodule // dlcr_panel_model

// *** testbench/testbench.sv ***
`timescale 1ns/100ps
module testbench;
  import dlcr_pkg::*;
  localparam int CPM = 10;
  logic          core_clk, reset, pll_lock_pin, hsync_pin, vsync_pin, sync_run, order_fault, reg_rvalid;
  logic          link_pixel_valid, input_buffer_select, link_enable, link_path_off, odd_even_swap, config_strap;
  logic          wide_output_select, panel_power_enable, backlight_enable, bit_mapping_standard_select;
  logic [2:0]    input_format_select;
  logic [7:0]    reg_rdata, d;
  dlcr_reg_req_t reg_req;
  dlcr_pixel_t   pixel_in, link_pixel;
  int            miscompares = 0, tests_run = 0, seed = 32'h8A82;
  dlcr_top #(.CYCLES_PER_MS(CPM)) dlcr_top_inst (.*, .pixel_in_valid(1'b1));
  dlcr_panel_model dlcr_panel_model_inst (.*);
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  function automatic int nine_ms(input logic [8:0] f);
    return (f + 1 < MIN_DELAY_MS) ? MIN_DELAY_MS : f + 1;
  endfunction
  function automatic int seven_ms(input logic [6:0] f);
    return 2 * f + 2;
  endfunction
  task automatic check(input logic [23:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    if (miscompares == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // One access then an idle cycle, so no strobe is driven twice in one step
  task automatic acc(input logic [7:0] a, input logic w, input logic [7:0] e);
    reg_req <= '{a, w, !w, e};
    @(negedge core_clk);
    reg_req <= '0;
    if (!w) check(24'({reg_rvalid, reg_rdata}), 24'({1'b1, e}));
    @(negedge core_clk);
  endtask
  task automatic meas(input int s, input int ms);
    int n = 0;
    while (n < 4000 && (s == 0 ? !link_enable : s == 1 ? !backlight_enable : s == 2 ? backlight_enable
           : s == 3 ? link_enable : panel_power_enable)) begin
      @(negedge core_clk);
      n++;
    end
    check(24'(n >= (ms - 1) * CPM && n <= (ms + 2) * CPM), 24'h1);
  endtask
  initial begin
    logic [7:0] ra[12] = '{8'h1F, 8'h31, 8'h48, 8'h4A, 8'h4B, 8'h63, 8'h64, 8'h66, 8'h67, 8'h68, 8'h69, 8'h00};
    logic [7:0] rv[12] = '{8'h80, 8'h00, 8'h18, VERSION_CODE_VALUE, DEVICE_CODE_BASE | 8'h21, 8'h00, 8'h0D,
                           8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
    reset = 1'b1;
    reg_req = '0;
    pll_lock_pin = 1'b0;
    config_strap = 1'b1;
    sync_run = 1'b0;
    pixel_in = '0;
    repeat (3) @(negedge core_clk);
    reset = 1'b0;
    foreach (ra[i]) acc(ra[i], 1'b0, rv[i]);
    acc(8'h4A, 1'b1, 8'h00);
    acc(8'h4A, 1'b0, VERSION_CODE_VALUE);
    acc(8'h66, 1'b1, 8'h19);
    repeat (100) @(negedge core_clk);
    check(24'(link_enable), 24'h0);
    acc(8'h67, 1'b1, 8'h02);
    acc(8'h68, 1'b1, 8'h82);
    acc(8'h69, 1'b1, 8'h81);
    acc(8'h6A, 1'b1, 8'h01);
    acc(8'h66, 1'b1, 8'h3B);
    meas(0, nine_ms(9'h102));
    meas(1, seven_ms(7'h02));
    pixel_in = 24'($random(seed));
    acc(8'h64, 1'b1, 8'h2F);
    check(24'({wide_output_select, bit_mapping_standard_select, odd_even_swap}), 24'h7);
    for (int p = 3; p >= 0; p--) begin
      acc(8'h48, 1'b1, 8'h18 | 8'(p));
      repeat (4) @(negedge core_clk);
      if (p[0] == p[1]) check(link_pixel, p ? 24'h0 : pixel_in);
      else if (p == 2) check(24'({link_pixel.red ^ link_pixel.green, link_pixel.blue ^ link_pixel.green}), 24'h0);
    end
    check(24'(link_pixel_valid), 24'h1);
    acc(8'h48, 1'b1, 8'h10);
    repeat (4) @(negedge core_clk);
    check(24'(link_pixel_valid), 24'h0);
    acc(8'h48, 1'b1, 8'h18);
    repeat (20) begin
      d = 8'($random(seed));
      acc(8'h1F, 1'b1, d);
      acc(8'h1F, 1'b0, d);
      check(24'({input_buffer_select, input_format_select}), 24'({d[7], d[2:0]}));
      acc(8'h31, 1'b1, d);
      acc(8'h31, 1'b0, d);
    end
    acc(8'h66, 1'b1, 8'hFF);
    acc(8'h66, 1'b0, 8'h3B);
    sync_run = 1'b1;
    pll_lock_pin = 1'b1;
    repeat (100) @(negedge core_clk);
    acc(8'h66, 1'b0, 8'h7F);
    acc(8'h66, 1'b1, 8'h3A);
    meas(2, 0);
    meas(3, seven_ms(7'h01));
    meas(4, nine_ms(9'h101));
    acc(8'h48, 1'b1, 8'h08);
    acc(8'h48, 1'b0, 8'h18);
    acc(8'h64, 1'b0, 8'h0D);
    acc(8'h63, 1'b1, 8'h40);
    check(24'(link_path_off), 24'h1);
    repeat (4) @(negedge core_clk);
    check(24'({link_enable, link_pixel_valid}), 24'h0);
    config_strap = 1'b0;
    repeat (4) @(negedge core_clk);
    acc(8'h4B, 1'b0, DEVICE_CODE_BASE);
    end_sim();
  end
  always @(negedge core_clk) if (order_fault === 1'b1) check(24'h1, 24'h0);
  initial begin
    #100000;
    miscompares++;
    end_sim();
  end
endmodule // testbench
